// ==== verilog/bus_cmd_pkg.sv ====
// constants and types for the status-driven bus command controller
package bus_cmd_pkg;
  // cycle status codes on the three status lines (s2 s1 s0)
  localparam logic [2:0] ST_INTERRUPT_ACKNOWLEDGE_COMMAND = 3'h0;
  localparam logic [2:0] ST_IORD = 3'h1;
  localparam logic [2:0] ST_IOWR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEMRD = 3'h5;
  localparam logic [2:0] ST_MEMWR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;
  // status bit that separates memory from i/o
  localparam int MEM_IO_BIT = 2;
  // transceiver direction levels
  localparam logic DIR_TRANSMIT = 1'b1;
  localparam logic DIR_RECEIVE = 1'b0;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_T1,
    PH_T2,
    PH_T3,
    PH_T4
  } phase_type;

  typedef enum logic [2:0] {
    K_NONE,
    K_READ,
    K_WRITE,
    K_INTERRUPT_ACKNOWLEDGE_COMMAND,
    K_HALT
  } kind_type;
endpackage

// ==== verilog/bus_cmd_ctrl.sv ====
// status-driven bus command controller, one clock per bus T state
// What this block does
// - leaving passive status starts cycle, strobe in T1
// - address strobe ends at T2 rising edge
// - separate memory/io reads, T2 to T4
// - read: receive direction T1, enable from T2
// - direction back to transmit at T4
// - advanced write one clock before normal
// - acknowledge cycles drive like a read
// - non-io mode: cascade enable in acknowledge, T1
// - cascade enable outlasts the address strobe
// - io mode: pin is peripheral enable, io local
// - io mode: peripheral enable for io only
// - third status line marks memory versus io
// - halt code: strobe pulse, no command
module bus_cmd_ctrl
  import bus_cmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // processor side
  input wire logic [2:0] cycle_status_lines,
  input wire logic ready,
  // strap
  input wire logic io_bus_strap_mode,
  // latch strobe
  output logic address_strobe,
  // commands, active low
  output logic mem_read_cmd_n,
  output logic io_read_cmd_n,
  output logic mem_write_cmd_n,
  output logic io_write_cmd_n,
  output logic adv_mem_write_cmd_n,
  output logic adv_io_write_cmd_n,
  output logic interrupt_acknowledge_command_n,
  // transceiver control
  output logic transceiver_direction,
  output logic transceiver_enable,
  output logic cascade_or_peripheral_enable_pin,
  // memory versus io early indication
  output logic io_cycle
);

  // cycle tracking state
  phase_type phase_r;
  phase_type phase_nxt;
  kind_type kind_r;
  kind_type kind_nxt;
  logic is_io_r;
  logic is_io_nxt;
  logic iob_r;
  logic [2:0] status_prev_r;
  logic start;
  logic is_io_now;
  // phase windows for the outputs
  logic strobe_nxt;
  logic cmd_win;
  logic norm_win;
  logic xcv_win;
  // per-output next values
  logic mem_read_nxt;
  logic io_read_nxt;
  logic adv_mem_write_nxt;
  logic adv_io_write_nxt;
  logic mem_write_nxt;
  logic io_write_nxt;
  logic ack_nxt;
  // transceiver helpers
  logic rx_kind;
  logic rx_win;
  logic en_active;
  logic sys_en;
  logic per_en;
  logic casc_first;
  logic casc_hold;
  logic casc_en;

  // cycle starts when status leaves passive
  assign start = (status_prev_r == ST_PASSIVE) && (cycle_status_lines != ST_PASSIVE);
  // memory/io decided by third status line; acknowledge counts as io
  assign is_io_now = ~cycle_status_lines[MEM_IO_BIT];

  // last sampled status, for the passive-exit edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_prev_r <= ST_PASSIVE;
    end else begin
      status_prev_r <= cycle_status_lines;
    end
  end

  // strap caught in the clocked domain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      iob_r <= 1'b0;
    end else if (phase_r == PH_IDLE) begin
      iob_r <= io_bus_strap_mode;
    end
  end

  // next phase and latched cycle kind
  always_comb begin
    phase_nxt = phase_r;
    kind_nxt = kind_r;
    is_io_nxt = is_io_r;
    case (phase_r)
      PH_IDLE, PH_T4: begin
        if (start) begin
          phase_nxt = PH_T1;
          is_io_nxt = is_io_now;
          case (cycle_status_lines)
            ST_INTERRUPT_ACKNOWLEDGE_COMMAND: kind_nxt = K_INTERRUPT_ACKNOWLEDGE_COMMAND;
            ST_IORD, ST_MEMRD, ST_FETCH: kind_nxt = K_READ;
            ST_IOWR, ST_MEMWR: kind_nxt = K_WRITE;
            ST_HALT: kind_nxt = K_HALT;
            default: kind_nxt = K_NONE;
          endcase
        end else begin
          phase_nxt = PH_IDLE;
          kind_nxt = K_NONE;
        end
      end
      PH_T1: phase_nxt = (kind_r == K_HALT) ? PH_IDLE : PH_T2;
      PH_T2: phase_nxt = PH_T3;
      PH_T3: phase_nxt = ready ? PH_T4 : PH_T3;
      default: phase_nxt = PH_IDLE;
    endcase
  end

  // bus phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // kind latched at cycle start, mid-cycle status ignored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      kind_r <= K_NONE;
    end else begin
      kind_r <= kind_nxt;
    end
  end

  // memory versus io of the running cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      is_io_r <= 1'b0;
    end else begin
      is_io_r <= is_io_nxt;
    end
  end

  // strobe high only during T1, dropped at its end edge
  assign strobe_nxt = (phase_nxt == PH_T1);
  // read-style window: T2 through wait states, off after T4 starts
  assign cmd_win = (phase_nxt == PH_T2) || (phase_nxt == PH_T3);
  assign norm_win = (phase_nxt == PH_T3);
  assign xcv_win = cmd_win;

  // command decode, active high here
  assign mem_read_nxt = cmd_win && (kind_nxt == K_READ) && !is_io_nxt;
  assign io_read_nxt = cmd_win && (kind_nxt == K_READ) && is_io_nxt;
  assign adv_mem_write_nxt = cmd_win && (kind_nxt == K_WRITE) && !is_io_nxt;
  assign adv_io_write_nxt = cmd_win && (kind_nxt == K_WRITE) && is_io_nxt;
  assign mem_write_nxt = norm_win && (kind_nxt == K_WRITE) && !is_io_nxt;
  assign io_write_nxt = norm_win && (kind_nxt == K_WRITE) && is_io_nxt;
  assign ack_nxt = cmd_win && (kind_nxt == K_INTERRUPT_ACKNOWLEDGE_COMMAND);

  // receive from T1 until the T4 edge
  assign rx_kind = (kind_nxt == K_READ) || (kind_nxt == K_INTERRUPT_ACKNOWLEDGE_COMMAND);
  assign rx_win = rx_kind && ((phase_nxt == PH_T1) || cmd_win);
  assign en_active = xcv_win && (kind_nxt != K_HALT) && (kind_nxt != K_NONE);
  // io mode: io (incl. acknowledge) goes to the local peripheral enable
  assign sys_en = en_active && !(iob_r && is_io_nxt);
  assign per_en = en_active && is_io_nxt;
  // cascade enable through T1 and one cycle past the strobe fall
  assign casc_first = (phase_nxt == PH_T1);
  assign casc_hold = (phase_nxt == PH_T2) && (phase_r == PH_T1);
  assign casc_en = (kind_nxt == K_INTERRUPT_ACKNOWLEDGE_COMMAND) && (casc_first || casc_hold);

  // latch strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      address_strobe <= 1'b0;
    end else begin
      address_strobe <= strobe_nxt;
    end
  end

  // memory read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_read_cmd_n <= 1'b1;
    end else begin
      mem_read_cmd_n <= ~mem_read_nxt;
    end
  end

  // io read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      io_read_cmd_n <= 1'b1;
    end else begin
      io_read_cmd_n <= ~io_read_nxt;
    end
  end

  // advanced memory write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adv_mem_write_cmd_n <= 1'b1;
    end else begin
      adv_mem_write_cmd_n <= ~adv_mem_write_nxt;
    end
  end

  // advanced io write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adv_io_write_cmd_n <= 1'b1;
    end else begin
      adv_io_write_cmd_n <= ~adv_io_write_nxt;
    end
  end

  // normal memory write, one clock behind the advanced one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_write_cmd_n <= 1'b1;
    end else begin
      mem_write_cmd_n <= ~mem_write_nxt;
    end
  end

  // normal io write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      io_write_cmd_n <= 1'b1;
    end else begin
      io_write_cmd_n <= ~io_write_nxt;
    end
  end

  // acknowledge command
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_acknowledge_command_n <= 1'b1;
    end else begin
      interrupt_acknowledge_command_n <= ~ack_nxt;
    end
  end

  // transceiver direction
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transceiver_direction <= DIR_TRANSMIT;
    end else begin
      transceiver_direction <= rx_win ? DIR_RECEIVE : DIR_TRANSMIT;
    end
  end

  // system transceiver enable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transceiver_enable <= 1'b0;
    end else begin
      transceiver_enable <= sys_en;
    end
  end

  // shared pin, meaning set by the strap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cascade_or_peripheral_enable_pin <= 1'b0;
    end else begin
      cascade_or_peripheral_enable_pin <= iob_r ? per_en : casc_en;
    end
  end

  // early io indication
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      io_cycle <= 1'b0;
    end else begin
      io_cycle <= (phase_nxt != PH_IDLE) && is_io_nxt;
    end
  end

endmodule // bus_cmd_ctrl

// ==== testbench/status_source.sv ====
// processor status source with ready for the bus command controller
module status_source
  import bus_cmd_pkg::*;
(
  // clock
  input wire logic clock,
  // status bus and ready
  output logic [2:0] cycle_status_lines,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cycle_status_lines = ST_PASSIVE;
    ready = 1'b1;
  end
  // code for one clock then passive, ready low for the wait count
  task automatic run(input logic [2:0] code, input int waits);
    @(negedge clock);
    cycle_status_lines = code;
    ready = (waits == 0);
    @(negedge clock);
    cycle_status_lines = ST_PASSIVE;
    repeat (2 + waits) @(negedge clock);
    ready = 1'b1;
    @(negedge clock);
  endtask
endmodule // status_source

// ==== testbench/bus_cmd_ctrl_monitor.sv ====
// assertions on the bus command controller ports
module bus_cmd_ctrl_monitor
  import bus_cmd_pkg::*;
(
  // clock, reset and inputs
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic io_bus_strap_mode,
  input wire logic [2:0] cycle_status_lines,
  // outputs watched
  input wire logic address_strobe,
  input wire logic mem_read_cmd_n,
  input wire logic io_read_cmd_n,
  input wire logic mem_write_cmd_n,
  input wire logic adv_mem_write_cmd_n,
  input wire logic interrupt_acknowledge_command_n,
  input wire logic transceiver_direction,
  input wire logic transceiver_enable,
  input wire logic cascade_or_peripheral_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  start_strobe_a: assert property ($past(cycle_status_lines) == ST_PASSIVE && cycle_status_lines != ST_PASSIVE
    |=> address_strobe) else $error("strobe missing");
  strobe_end_a: assert property (address_strobe |=> !address_strobe) else $error("strobe too long");
  read_start_a: assert property ($fell(mem_read_cmd_n) |-> $past(address_strobe)) else $error("read early");
  enable_start_a: assert property ($rose(transceiver_enable) |-> $past(address_strobe)) else $error("enable");
  dir_back_a: assert property ($rose(mem_read_cmd_n) |-> transceiver_direction) else $error("direction");
  adv_write_a: assert property ($fell(adv_mem_write_cmd_n) |=> $fell(mem_write_cmd_n)) else $error("write");
  halt_quiet_a: assert property ($past(cycle_status_lines) == ST_PASSIVE && cycle_status_lines == ST_HALT
    |=> ##1 (interrupt_acknowledge_command_n && mem_read_cmd_n && !transceiver_enable)[*3]) else $error("halt");
  cascade_hold_a: assert property (!io_bus_strap_mode && $fell(interrupt_acknowledge_command_n)
    |-> cascade_or_peripheral_enable_pin && $past(cascade_or_peripheral_enable_pin)) else $error("cascade");
  periph_en_a: assert property (io_bus_strap_mode && !io_read_cmd_n
    |-> cascade_or_peripheral_enable_pin && !transceiver_enable) else $error("peripheral enable");
  wait_hold_a: assert property ($fell(mem_read_cmd_n) ##1 !ready |=> !mem_read_cmd_n) else $error("wait");
endmodule // bus_cmd_ctrl_monitor
bind bus_cmd_ctrl bus_cmd_ctrl_monitor u_bus_cmd_ctrl_monitor (.*);

// ==== testbench/test_bus_cmd_ctrl.sv ====
// self-checking bench for the bus command controller
module test_bus_cmd_ctrl
  import bus_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, io_bus_strap_mode = 1'b0, ready, address_strobe, io_cycle;
  logic transceiver_direction, transceiver_enable, cascade_or_peripheral_enable_pin;
  logic [2:0] cycle_status_lines;
  logic [6:0] cmds;
  int fail_count = 0, checks_done = 0;
  always #12.5 clock = ~clock;
  status_source u_status_source(.clock(clock), .cycle_status_lines(cycle_status_lines), .ready(ready));
  bus_cmd_ctrl u_bus_cmd_ctrl(.clock(clock), .rst_n(rst_n), .cycle_status_lines(cycle_status_lines), .ready(ready),
    .io_bus_strap_mode(io_bus_strap_mode), .address_strobe(address_strobe), .mem_read_cmd_n(cmds[6]),
    .io_read_cmd_n(cmds[5]), .mem_write_cmd_n(cmds[4]), .io_write_cmd_n(cmds[3]), .adv_mem_write_cmd_n(cmds[2]),
    .adv_io_write_cmd_n(cmds[1]), .interrupt_acknowledge_command_n(cmds[0]),
    .transceiver_direction(transceiver_direction), .transceiver_enable(transceiver_enable),
    .cascade_or_peripheral_enable_pin(cascade_or_peripheral_enable_pin), .io_cycle(io_cycle));
  task automatic chk7(string n, logic [6:0] e, logic [6:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk7(n, {6'h00, e}, {6'h00, g});
  endtask
  // one cycle: T1 strobe and direction, T2 commands and enables, T4 all idle
  task automatic bus_cycle(input logic [2:0] code, input int waits, input logic [6:0] c, input logic d1, e2, p2);
    fork
      u_status_source.run(code, waits);
      begin
        repeat (2) @(negedge clock);
        chk1("strobe", 1'b1, address_strobe);
        chk1("direction", d1, transceiver_direction);
        @(negedge clock);
        chk1("strobe", 1'b0, address_strobe);
        chk7("commands", c, cmds);
        chk1("enable", e2, transceiver_enable);
        chk1("shared pin", p2, cascade_or_peripheral_enable_pin);
        if (c != 7'h7F) chk1("io cycle", !code[MEM_IO_BIT], io_cycle);
        @(negedge clock);
        chk7("commands T3", c & {2'b11, c[2], c[1], 3'h7}, cmds);
        repeat (1 + waits) @(negedge clock);
        chk7("commands", 7'h7F, cmds);
        chk1("direction", 1'b1, transceiver_direction);
      end
    join
  endtask
  task automatic test_reads();
    bus_cycle(ST_MEMRD, 1, 7'h3F, 1'b0, 1'b1, 1'b0);
    bus_cycle(ST_IORD, 0, 7'h5F, 1'b0, 1'b1, 1'b0);
    bus_cycle(ST_FETCH, 0, 7'h3F, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic test_writes();
    bus_cycle(ST_MEMWR, 0, 7'h7B, 1'b1, 1'b1, 1'b0);
    bus_cycle(ST_IOWR, 2, 7'h7D, 1'b1, 1'b1, 1'b0);
  endtask
  task automatic test_ack_halt();
    bus_cycle(ST_INTERRUPT_ACKNOWLEDGE_COMMAND, 0, 7'h7E, 1'b0, 1'b1, 1'b1);
    bus_cycle(ST_INTERRUPT_ACKNOWLEDGE_COMMAND, 0, 7'h7E, 1'b0, 1'b1, 1'b1);
    bus_cycle(ST_HALT, 0, 7'h7F, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic test_io_mode();
    io_bus_strap_mode = 1'b1;
    @(negedge clock);
    bus_cycle(ST_IORD, 0, 7'h5F, 1'b0, 1'b0, 1'b1);
    bus_cycle(ST_INTERRUPT_ACKNOWLEDGE_COMMAND, 0, 7'h7E, 1'b0, 1'b0, 1'b1);
    bus_cycle(ST_MEMRD, 0, 7'h3F, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    test_reads();
    test_writes();
    test_ack_halt();
    test_io_mode();
    report_and_stop();
  end
endmodule // test_bus_cmd_ctrl
